/* hdl/wbb_dev.sv */
`timescale 1ns/100ps
module wbb_dev (
  // Clock and reset.
  input logic clk_sys,
  input logic rst_b,
  // Bus towards the memory controller.
  wbb_if.dev bus,
  // Core-side configuration and control.
  input logic enhancedMode,
  input logic softResetIn,
  input logic purgeIn,
  input logic purgeLinesDone,
  // Core-side request.
  input logic reqValid,
  input wbb_pkg::wbb_kind_e reqKind,
  input logic [31:0] reqAddr,
  input logic [31:0] reqData,
  input logic [127:0] reqLine,
  input logic reqCacheable,
  input logic reqBurst,
  input logic reqPageNoStore,
  input logic reqPwt,
  // Core-side results.
  output logic reqTaken,
  output logic [31:0] rdData,
  output logic rdValid,
  output logic done,
  output logic lineCached,
  output logic lineIsWriteBack,
  output logic cacheInvalidate,
  output logic purgeActive,
  output logic purgeDone
);
  import wbb_pkg::*;

  wbb_dev_s r;
  wbb_dev_s next_r;
  logic burst_ready_in;
  logic rdy;
  logic ack;
  logic [1:0] nextCnt;
  logic firstKen;
  logic finish;

  // Bus pins and core results come straight from the state register.
  assign bus.addrStrobe_b = r.addrStrobe_b;
  assign bus.addr = r.addr;
  assign bus.writeRead = r.writeRead;
  assign bus.memIo = r.memIo;
  assign bus.dataCode = r.dataCode;
  assign bus.byteEn_b = r.byteEn_b;
  assign bus.lineStore_b = r.lineStore_b;
  assign bus.pageNoStore = r.pageNoStore;
  assign bus.pageWriteThrough = r.pageWriteThrough;
  assign bus.lastTransfer_b = r.lastTransfer_b;
  assign bus.pseudoLock_b = r.pseudoLock_b;
  assign bus.dataOut = r.dataOut;
  assign reqTaken = r.reqTaken;
  assign rdData = r.rdData;
  assign rdValid = r.rdValid;
  assign done = r.done;
  assign lineCached = r.lineCached;
  assign lineIsWriteBack = r.lineIsWriteBack;
  assign cacheInvalidate = r.cacheInvalidate;
  assign purgeActive = r.purgeActive;
  assign purgeDone = r.purgeDone;

  // Readies are active low and sampled on the rising edge.
  assign burst_ready_in = !bus.burstReady_b;
  assign rdy = !bus.ready_b;
  assign ack = burst_ready_in || rdy;
  assign nextCnt = r.cnt + 2'h1;
  assign firstKen = r.firstDone ? r.kenFirst : r.kenPrev;

  // Cycle sequencing, address order and cacheability decisions.
  always_comb begin
    next_r = r;
    finish = 1'b0;
    next_r.reqTaken = 1'b0;
    next_r.rdValid = 1'b0;
    next_r.done = 1'b0;
    next_r.cacheInvalidate = 1'b0;
    next_r.purgeDone = 1'b0;
    next_r.addrStrobe_b = 1'b1;
    next_r.pseudoLock_b = 1'b1;
    next_r.kenPrev = !bus.fillAllow_b;
    case (r.state)
      S_IDLE: begin
        if (softResetIn) begin
          // A soft reset only flushes the cache outside enhanced mode.
          next_r.cacheInvalidate = !enhancedMode;
        end else if (r.purgeActive && purgeLinesDone) begin
          // All modified lines are out; open the first flush acknowledge.
          next_r.state = S_ADDR;
          next_r.kind = K_SPEC;
          next_r.addrStrobe_b = 1'b0;
          next_r.addr = WBB_SPEC_ADDR_ACK;
          next_r.byteEn_b = WBB_BE_FLUSH1_B;
          next_r.memIo = 1'b0;
          next_r.dataCode = 1'b0;
          next_r.writeRead = 1'b1;
          next_r.lastTransfer_b = 1'b0;
          next_r.specSecond = 1'b0;
        end else if (purgeIn && !r.purgeActive && enhancedMode) begin
          next_r.purgeActive = 1'b1;
        end else if (purgeIn && !r.purgeActive) begin
          // Write-through cache: invalidate and issue one flush cycle.
          next_r.cacheInvalidate = 1'b1;
          next_r.state = S_ADDR;
          next_r.kind = K_SPEC;
          next_r.addrStrobe_b = 1'b0;
          next_r.addr = WBB_SPEC_ADDR_FLUSH;
          next_r.byteEn_b = WBB_BE_FLUSH2_B;
          next_r.memIo = 1'b0;
          next_r.dataCode = 1'b0;
          next_r.writeRead = 1'b1;
          next_r.lastTransfer_b = 1'b0;
          next_r.specSecond = 1'b1;
        end else if (reqValid) begin
          next_r.reqTaken = 1'b1;
          next_r.state = S_ADDR;
          next_r.kind = reqKind;
          next_r.addrStrobe_b = 1'b0;
          next_r.memIo = 1'b1;
          next_r.dataCode = 1'b1;
          next_r.byteEn_b = WBB_BE_ALL_B;
          next_r.writeRead = (reqKind != K_READ);
          next_r.cnt = 2'h0;
          next_r.firstDone = 1'b0;
          next_r.line = reqLine;
          next_r.burstNc = reqBurst && (reqKind == K_READ);
          next_r.pageWriteThrough = reqPwt;
          if (reqKind == K_WBACK) begin
            // Write-backs always start at offset zero and ask for a burst.
            next_r.start = WBB_WB_START;
            next_r.addr = {reqAddr[31:4], WBB_WB_START, 2'h0};
            next_r.dataOut = reqLine[31:0];
            next_r.lsc = enhancedMode;
            next_r.lineStore_b = !enhancedMode;
            next_r.pageNoStore = 1'b0;
            next_r.lastTransfer_b = 1'b1;
          end else begin
            next_r.start = reqAddr[3:2];
            next_r.addr = {reqAddr[31:2], 2'h0};
            next_r.dataOut = reqData;
            next_r.lsc = enhancedMode && reqCacheable && (reqKind == K_READ);
            next_r.lineStore_b = !(enhancedMode && reqCacheable && (reqKind == K_READ));
            next_r.pageNoStore = (enhancedMode && reqCacheable) || reqPageNoStore;
            next_r.lastTransfer_b = 1'b0;
          end
        end
      end
      S_ADDR: begin
        next_r.state = S_DATA;
      end
      S_DATA: begin
        if (ack) begin
          if (!r.firstDone) begin
            next_r.firstDone = 1'b1;
            next_r.kenFirst = r.kenPrev;
            next_r.lineStore_b = 1'b1;
            if (r.kind == K_READ) begin
              next_r.lineIsWriteBack = bus.writeBackSelect && !r.pageWriteThrough;
            end
          end
          if (r.kind == K_READ) begin
            next_r.rdData = bus.dataIn;
            next_r.rdValid = 1'b1;
          end
          if (r.kind == K_WBACK && rdy && r.cnt != WBB_LAST_BEAT) begin
            // Non-burst write-back: each doubleword is its own cycle.
            next_r.state = S_ADDR;
            next_r.addrStrobe_b = 1'b0;
            next_r.cnt = nextCnt;
            next_r.addr[3:2] = nextCnt;
            next_r.dataOut = r.line[32*nextCnt +: 32];
          end else if (rdy || !r.lastTransfer_b) begin
            finish = 1'b1;
          end else begin
            // Burst continues; addresses follow the start-dependent order.
            next_r.cnt = nextCnt;
            next_r.addr[3:2] = r.start ^ nextCnt;
            next_r.dataOut = r.line[32*(r.start ^ nextCnt) +: 32];
            next_r.lastTransfer_b = (nextCnt != WBB_LAST_BEAT);
          end
        end else if (r.kind == K_READ && !r.firstDone) begin
          // Last-transfer stays high, so the burst goes on, when fill-allow is offered one clock ahead
          // on a line-store or standard-mode read, or when the core asked for a burst read.
          next_r.lastTransfer_b = ((r.lsc || !enhancedMode) && !bus.fillAllow_b)
                                  || r.burstNc;
        end
        if (finish) begin
          next_r.state = S_IDLE;
          next_r.done = 1'b1;
          next_r.lineStore_b = 1'b1;
          next_r.lastTransfer_b = 1'b1;
          next_r.byteEn_b = WBB_BE_NONE_B;
          if (r.kind == K_READ) begin
            // Fill-allow must be seen before both the first and last ready.
            next_r.lineCached = r.lsc && firstKen && r.kenPrev
                                && (r.cnt == WBB_LAST_BEAT);
          end else if (r.kind == K_SPEC && !r.specSecond) begin
            next_r.state = S_ADDR;
            next_r.done = 1'b0;
            next_r.addrStrobe_b = 1'b0;
            next_r.addr = WBB_SPEC_ADDR_ACK;
            next_r.byteEn_b = WBB_BE_FLUSH2_B;
            next_r.lastTransfer_b = 1'b0;
            next_r.specSecond = 1'b1;
            next_r.firstDone = 1'b0;
          end else if (r.kind == K_SPEC && r.purgeActive) begin
            next_r.purgeActive = 1'b0;
            next_r.cacheInvalidate = 1'b1;
            next_r.purgeDone = 1'b1;
          end
          // Write-back cycles never touch cacheability results.
          if (r.kind == K_WBACK) begin
            next_r.lineCached = r.lineCached;
          end
        end
      end
      default: begin
        next_r = WBB_DEV_RESET;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      r <= WBB_DEV_RESET;
    end else begin
      r <= next_r;
    end
  end

endmodule

/* hdl/wbb_pkg.sv */
// Operation
// - Write-back cache selects enhanced bus mode.
// - Four-doubleword write bursts only for write-backs.
// - Enhanced soft reset leaves the cache alone.
// - Enhanced purge: write back, invalidate, two specials; code invalidates after the specials.
// - Enhanced mode keeps pseudo-lock deasserted.
// - Cacheable cycle asserts page-no-store and line-store.
// - Fill-allow before first burst-ready makes bursts.
// - Fill-allow needed before first and last ready.
// - Read data taken only on burst-ready; gaps allowed; code also takes it on ready.
// - Cacheable read with fill-allow keeps last-transfer high.
// - Non-cacheable burst: last-transfer high at first ready.
// - Controller should finish non-cacheable bursts fully.
// - Line-store on writes only for four-word write-backs.
// - Write-backs ignore fill-allow and write-back-select.
// - Aligned four-word bursts, order set by start.
// - Line-store with direction marks fill or write-back.
// - Line-store valid from strobe to first ready.
// - Page-no-store low during write-back cycles.
// - Write-back-select sampled once, combined with write-through.
// - Strobe to last-transfer timing same in both modes.
// - Write-backs use order 0, 4, 8, C.
package wbb_pkg;

  localparam int WBB_WORDS = 4;
  localparam logic [1:0] WBB_LAST_BEAT = 2'h3;
  localparam logic [1:0] WBB_WB_START = 2'h0;
  localparam logic [3:0] WBB_BE_ALL_B = 4'h0;
  localparam logic [3:0] WBB_BE_NONE_B = 4'hf;
  localparam logic [3:0] WBB_BE_FLUSH1_B = 4'h7;
  localparam logic [3:0] WBB_BE_FLUSH2_B = 4'hd;
  localparam logic [31:0] WBB_SPEC_ADDR_ACK = 32'h00000004;
  localparam logic [31:0] WBB_SPEC_ADDR_FLUSH = 32'h00000000;
  localparam int WBB_MEM_WORDS = 64;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_DATA = 3'b010
  } wbb_state_e;

  typedef enum logic [1:0] {
    K_READ = 2'b00,
    K_WRITE = 2'b01,
    K_WBACK = 2'b10,
    K_SPEC = 2'b11
  } wbb_kind_e;

  typedef struct packed {
    wbb_state_e state;
    wbb_kind_e kind;
    logic [1:0] cnt;
    logic [1:0] start;
    logic [127:0] line;
    logic lsc;
    logic burstNc;
    logic firstDone;
    logic kenPrev;
    logic kenFirst;
    logic purgeActive;
    logic specSecond;
    logic addrStrobe_b;
    logic [31:0] addr;
    logic writeRead;
    logic memIo;
    logic dataCode;
    logic [3:0] byteEn_b;
    logic lineStore_b;
    logic pageNoStore;
    logic pageWriteThrough;
    logic lastTransfer_b;
    logic pseudoLock_b;
    logic [31:0] dataOut;
    logic reqTaken;
    logic [31:0] rdData;
    logic rdValid;
    logic done;
    logic lineCached;
    logic lineIsWriteBack;
    logic cacheInvalidate;
    logic purgeDone;
  } wbb_dev_s;

  localparam wbb_dev_s WBB_DEV_RESET = '{
    state: S_IDLE, kind: K_READ, addrStrobe_b: 1'b1, byteEn_b: 4'hf,
    lineStore_b: 1'b1, lastTransfer_b: 1'b1, pseudoLock_b: 1'b1, default: '0};

endpackage

/* hdl/wbb_if.sv */
`timescale 1ns/100ps
interface wbb_if;
  logic addrStrobe_b;
  logic [31:0] addr;
  logic writeRead;
  logic memIo;
  logic dataCode;
  logic [3:0] byteEn_b;
  logic lineStore_b;
  logic pageNoStore;
  logic pageWriteThrough;
  logic lastTransfer_b;
  logic pseudoLock_b;
  logic [31:0] dataOut;
  logic [31:0] dataIn;
  logic burstReady_b;
  logic ready_b;
  logic fillAllow_b;
  logic writeBackSelect;

  // Processor end drives address, status and write data.
  modport dev (
    output addrStrobe_b, addr, writeRead, memIo, dataCode, byteEn_b,
    output lineStore_b, pageNoStore, pageWriteThrough, lastTransfer_b,
    output pseudoLock_b, dataOut,
    input dataIn, burstReady_b, ready_b, fillAllow_b, writeBackSelect
  );

  // Memory controller end answers with readies, read data and cacheability.
  modport mem (
    input addrStrobe_b, addr, writeRead, memIo, dataCode, byteEn_b,
    input lineStore_b, pageNoStore, pageWriteThrough, lastTransfer_b,
    input pseudoLock_b, dataOut,
    output dataIn, burstReady_b, ready_b, fillAllow_b, writeBackSelect
  );
endinterface

/* hdl/wbb_mem.sv */
`timescale 1ns/100ps
module wbb_mem (
  // Clock and reset.
  input logic clk_sys,
  input logic rst_b,
  // Bus towards the processor.
  wbb_if.mem bus,
  // Answer policy.
  input logic allowFill,
  input logic selWriteBack,
  input logic slowBurst,
  input logic answerSingle,
  // Observation.
  output logic specialSeen,
  output logic [3:0] specialBe_b
);
  import wbb_pkg::*;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_WAIT = 2'b01,
    M_XFER = 2'b10
  } wbb_mstate_e;

  logic [31:0] memArray [WBB_MEM_WORDS];
  wbb_mstate_e state;
  wbb_mstate_e next_state;
  logic [3:0] line;
  logic [3:0] next_line;
  logic [1:0] start;
  logic [1:0] next_start;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic isWrite;
  logic next_isWrite;
  logic isSpec;
  logic next_isSpec;
  logic fillAllow_b;
  logic next_fillAllow_b;
  logic burst_ready_in_b;
  logic next_burst_ready_in_b;
  logic rdy_b;
  logic next_rdy_b;
  logic [31:0] dataIn;
  logic [31:0] next_dataIn;
  logic wbSel;
  logic next_wbSel;
  logic specSeen;
  logic next_specSeen;
  logic [3:0] specBe_b;
  logic [3:0] next_specBe_b;
  logic memWe;
  logic [5:0] idx;
  logic [5:0] nextIdx;
  logic acked;

  assign bus.fillAllow_b = fillAllow_b;
  assign bus.burstReady_b = burst_ready_in_b;
  assign bus.ready_b = rdy_b;
  assign bus.dataIn = dataIn;
  assign bus.writeBackSelect = wbSel;
  assign specialSeen = specSeen;
  assign specialBe_b = specBe_b;

  // Word index follows the same start-dependent order as the processor.
  assign idx = {line, start ^ cnt};
  assign nextIdx = {line, start ^ (cnt + 2'h1)};
  assign acked = !burst_ready_in_b || !rdy_b;
  assign memWe = (state == M_XFER) && acked && isWrite && !isSpec;

  // Answer sequencing for reads, writes, write-backs and special cycles.
  always_comb begin
    next_state = state;
    next_line = line;
    next_start = start;
    next_cnt = cnt;
    next_isWrite = isWrite;
    next_isSpec = isSpec;
    next_fillAllow_b = fillAllow_b;
    next_burst_ready_in_b = 1'b1;
    next_rdy_b = 1'b1;
    next_dataIn = dataIn;
    next_wbSel = wbSel;
    next_specSeen = 1'b0;
    next_specBe_b = specBe_b;
    case (state)
      M_IDLE: begin
        if (!bus.addrStrobe_b) begin
          next_state = M_WAIT;
          next_line = bus.addr[7:4];
          next_start = bus.addr[3:2];
          next_cnt = 2'h0;
          next_isWrite = bus.writeRead;
          next_isSpec = !bus.memIo;
          // Fill-allow is offered on reads only and held to the last ready.
          next_fillAllow_b = !(allowFill && !bus.writeRead && bus.memIo);
          next_wbSel = selWriteBack;
        end
      end
      M_WAIT: begin
        next_state = M_XFER;
        next_dataIn = memArray[idx];
        next_burst_ready_in_b = answerSingle || isSpec;
        next_rdy_b = !(answerSingle || isSpec);
      end
      M_XFER: begin
        if (!acked) begin
          // Gap cycle of a slow burst; resume with the same word.
          next_burst_ready_in_b = 1'b0;
        end else if (!rdy_b || !bus.lastTransfer_b) begin
          next_state = M_IDLE;
          next_fillAllow_b = 1'b1;
          next_specSeen = isSpec;
          next_specBe_b = isSpec ? bus.byteEn_b : specBe_b;
        end else begin
          // Keep bursting while last-transfer stays high, cacheable or not.
          next_cnt = cnt + 2'h1;
          next_dataIn = memArray[nextIdx];
          next_burst_ready_in_b = slowBurst;
        end
      end
      default: begin
        next_state = M_IDLE;
      end
    endcase
  end

  // Answer registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= M_IDLE;
      line <= 4'h0;
      start <= 2'h0;
      cnt <= 2'h0;
      isWrite <= 1'b0;
      isSpec <= 1'b0;
      fillAllow_b <= 1'b1;
      burst_ready_in_b <= 1'b1;
      rdy_b <= 1'b1;
      dataIn <= 32'h00000000;
      wbSel <= 1'b0;
      specSeen <= 1'b0;
      specBe_b <= WBB_BE_NONE_B;
    end else begin
      state <= next_state;
      line <= next_line;
      start <= next_start;
      cnt <= next_cnt;
      isWrite <= next_isWrite;
      isSpec <= next_isSpec;
      fillAllow_b <= next_fillAllow_b;
      burst_ready_in_b <= next_burst_ready_in_b;
      rdy_b <= next_rdy_b;
      dataIn <= next_dataIn;
      wbSel <= next_wbSel;
      specSeen <= next_specSeen;
      specBe_b <= next_specBe_b;
    end
  end

  // Backing store takes write data on each acknowledged write transfer, special cycles excepted.
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      memArray[idx] <= bus.dataOut;
    end
  end

endmodule

/* tb/wbb_chk.sv */
`timescale 1ns/100ps
// Watches the wires between the two ends and flags protocol slips.
module wbb_chk (
  // Clock and reset.
  input logic clk_sys,
  input logic rst_b,
  // Wires driven by the processor end.
  input logic addrStrobe_b,
  input logic [31:0] addr,
  input logic writeRead,
  input logic lineStore_b,
  input logic pageNoStore,
  input logic lastTransfer_b,
  input logic pseudoLock_b,
  // Wires driven by the controller end.
  input logic burstReady_b,
  input logic ready_b
);
  // Every check runs on the bus clock and sleeps through reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Pseudo-lock stays high in every cycle.
  chk_lock_stays_off: assert property (pseudoLock_b)
    else $error("pseudo-lock asserted");
  // The address strobe is a single-cycle pulse.
  chk_strobe_one_cycle: assert property (!addrStrobe_b |=> addrStrobe_b)
    else $error("address strobe held longer than one cycle");
  // A line-store write starts at doubleword offset zero.
  chk_wback_start_zero: assert property (
    !addrStrobe_b && !lineStore_b && writeRead |-> addr[3:2] == 2'h0)
    else $error("write-back does not start at offset zero");
  // Page-no-store is low while a write-back is announced.
  chk_wback_pcd_low: assert property (
    !addrStrobe_b && !lineStore_b && writeRead |-> !pageNoStore)
    else $error("page-no-store high on write-back");
  // A cacheable read shows page-no-store together with line-store.
  chk_fill_pcd_high: assert property (
    !addrStrobe_b && !lineStore_b && !writeRead |-> pageNoStore)
    else $error("page-no-store low on line-fill read");
  // Line-store goes away after the first ready unless a new strobe starts.
  chk_lsc_ends_ready: assert property (
    !lineStore_b && (!burstReady_b || !ready_b) |=> lineStore_b || !addrStrobe_b)
    else $error("line-store held past first ready");
  // Line-store only begins together with an address strobe.
  chk_lsc_starts_ads: assert property ($fell(lineStore_b) |-> !addrStrobe_b)
    else $error("line-store asserted without strobe");
  // Within a burst only the doubleword select may move.
  chk_burst_same_line: assert property (
    !burstReady_b && lastTransfer_b |=> $stable(addr[31:4]))
    else $error("burst left its sixteen-byte line");
endmodule

/* tb/writeback_burst_bus_tb_top.sv */
`timescale 1ns/100ps
// Drives both ends through their user sides and checks results.
module writeback_burst_bus_tb_top;
  import wbb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic enhancedMode = 1'b1, softResetIn = 1'b0, purgeIn = 1'b0, purgeLinesDone = 1'b0;
  logic reqValid = 1'b0, reqCacheable = 1'b0, reqBurst = 1'b0, reqPwt = 1'b0;
  wbb_kind_e reqKind = K_READ;
  logic [31:0] reqAddr = '0, reqData = '0, rdData;
  logic [127:0] reqLine = '0;
  logic reqTaken, rdValid, done, lineCached, lineIsWriteBack;
  logic cacheInvalidate, purgeActive, purgeDone, specialSeen;
  logic allowFill = 1'b0, selWriteBack = 1'b0, slowBurst = 1'b0, answerSingle = 1'b0;
  logic [3:0] specialBe_b;
  logic [31:0] got [0:3];
  logic [31:0] w [0:3];
  logic [7:0] beSeen = '0;
  logic lscSeen = 1'b0, firstLast = 1'b0;
  int nBeat = 0, nSpec = 0, nInval = 0, nRd, errTotal = 0, nTests = 0;

  wbb_if i_wbb_if ();
  wbb_dev i_wbb_dev (.clk_sys(clk_sys), .rst_b(rst_b), .bus(i_wbb_if),
    .enhancedMode(enhancedMode), .softResetIn(softResetIn), .purgeIn(purgeIn),
    .purgeLinesDone(purgeLinesDone), .reqValid(reqValid), .reqKind(reqKind),
    .reqAddr(reqAddr), .reqData(reqData), .reqLine(reqLine), .reqCacheable(reqCacheable),
    .reqBurst(reqBurst), .reqPageNoStore(1'b0), .reqPwt(reqPwt), .reqTaken(reqTaken),
    .rdData(rdData), .rdValid(rdValid), .done(done), .lineCached(lineCached),
    .lineIsWriteBack(lineIsWriteBack), .cacheInvalidate(cacheInvalidate),
    .purgeActive(purgeActive), .purgeDone(purgeDone));
  wbb_mem i_wbb_mem (.clk_sys(clk_sys), .rst_b(rst_b), .bus(i_wbb_if),
    .allowFill(allowFill), .selWriteBack(selWriteBack), .slowBurst(slowBurst),
    .answerSingle(answerSingle), .specialSeen(specialSeen), .specialBe_b(specialBe_b));
  wbb_chk i_wbb_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .addrStrobe_b(i_wbb_if.addrStrobe_b), .addr(i_wbb_if.addr),
    .writeRead(i_wbb_if.writeRead), .lineStore_b(i_wbb_if.lineStore_b),
    .pageNoStore(i_wbb_if.pageNoStore), .lastTransfer_b(i_wbb_if.lastTransfer_b),
    .pseudoLock_b(i_wbb_if.pseudoLock_b), .burstReady_b(i_wbb_if.burstReady_b),
    .ready_b(i_wbb_if.ready_b));

  // The bus clock toggles every 4 ns, giving a period of 8 ns.
  always #4 clk_sys = ~clk_sys;

  // Bus monitor: beats, line-store, last-transfer at first ready, specials.
  always @(posedge clk_sys) begin
    if (reqTaken) begin
      nBeat <= 0;
      lscSeen <= 1'b0;
    end else begin
      if (!i_wbb_if.burstReady_b || !i_wbb_if.ready_b) begin
        nBeat <= nBeat + 1;
        if (nBeat == 0) firstLast <= i_wbb_if.lastTransfer_b;
      end
      if (!i_wbb_if.lineStore_b) lscSeen <= 1'b1;
    end
    if (specialSeen) begin
      nSpec <= nSpec + 1;
      beSeen <= {beSeen[3:0], specialBe_b};
    end
    if (cacheInvalidate) nInval <= nInval + 1;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // Issues one request and gathers read beats until done.
  task automatic req(input wbb_kind_e k, input logic [31:0] a, input logic c, input logic b);
    int n;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqKind <= k;
    reqAddr <= a;
    reqCacheable <= c;
    reqBurst <= b;
    nRd = 0;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      reqValid <= 1'b0;
      #1;
      if (rdValid && nRd < 4) begin
        got[nRd] = rdData;
        nRd++;
      end
      if (done) break;
    end
    if (n == 100) check(32'h0, 32'h1);
    // Return on a rising edge so that the next stimulus lands on the clock.
    @(posedge clk_sys);
  endtask

  // Waits a bounded time for a pulse on the given flag.
  task automatic wait_pulse(ref logic flag);
    int n;
    for (n = 0; n < 200 && flag !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    check({31'h0, flag}, 32'h1);
    @(posedge clk_sys);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stopTest;
    $display("comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Gives up if the sequence hangs.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errTotal++;
    stopTest();
  end

  // Main sequence.
  initial begin
    for (int k = 0; k < 4; k++) w[k] = 32'h5a00_0000 + 32'h0101 * k;
    reqLine = {w[3], w[2], w[1], w[0]};
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Write-back as single transfers, with fill-allow and select both left off.
    answerSingle <= 1'b1;
    req(K_WBACK, 32'h0000_0020, 1'b1, 1'b1);
    check(nBeat, 4);
    check({31'h0, lscSeen}, 32'h1);
    $display("test write-back done");
    // Slow cacheable burst from offset 8 reads the line back in burst order.
    {answerSingle, allowFill, selWriteBack, slowBurst} <= 4'b0111;
    req(K_READ, 32'h0000_0028, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) check(got[k], w[k ^ 2]);
    check({31'h0, lineCached}, 32'h1);
    check({31'h0, lineIsWriteBack}, 32'h1);
    check({31'h0, firstLast}, 32'h1);
    $display("test line fill done");
    // A burst write-back leaves the fill results alone whatever select says.
    selWriteBack <= 1'b0;
    req(K_WBACK, 32'h0000_0020, 1'b1, 1'b1);
    check(nBeat, 4);
    check({31'h0, lineIsWriteBack}, 32'h1);
    check({31'h0, lineCached}, 32'h1);
    $display("test burst write-back done");
    // Cacheable read refused by fill-allow stays a single transfer.
    {allowFill, slowBurst, selWriteBack, reqPwt} <= 4'b0011;
    req(K_READ, 32'h0000_0028, 1'b1, 1'b0);
    check(nBeat, 1);
    check(got[0], w[2]);
    check({31'h0, firstLast}, 32'h0);
    check({31'h0, lineCached}, 32'h0);
    check({31'h0, lineIsWriteBack}, 32'h0);
    // Non-cacheable burst read keeps last-transfer high at first ready.
    reqPwt <= 1'b0;
    req(K_READ, 32'h0000_0020, 1'b0, 1'b1);
    check({31'h0, firstLast}, 32'h1);
    check({31'h0, lscSeen}, 32'h0);
    check(got[0], w[0]);
    $display("test non-cacheable reads done");
    // A plain write never uses line-store and reads back as written.
    reqData <= 32'habcd_0123;
    req(K_WRITE, 32'h0000_0040, 1'b0, 1'b0);
    check({31'h0, lscSeen}, 32'h0);
    check(nBeat, 1);
    req(K_READ, 32'h0000_0040, 1'b0, 1'b0);
    check(got[0], 32'habcd_0123);
    $display("test single write done");
    // Soft reset in enhanced mode leaves the cache untouched.
    softResetIn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    softResetIn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(nInval, 0);
    // Purge ends with two special cycles and one invalidation.
    purgeIn <= 1'b1;
    wait_pulse(purgeActive);
    @(posedge clk_sys);
    {purgeIn, purgeLinesDone} <= 2'b01;
    wait_pulse(purgeDone);
    @(posedge clk_sys);
    purgeLinesDone <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(nSpec, 2);
    check({24'h0, beSeen}, {24'h0, WBB_BE_FLUSH1_B, WBB_BE_FLUSH2_B});
    check(nInval, 1);
    $display("test soft reset and purge done");
    // Standard mode never drives line-store.
    {enhancedMode, allowFill} <= 2'b01;
    req(K_READ, 32'h0000_0020, 1'b1, 1'b1);
    check({31'h0, lscSeen}, 32'h0);
    check(got[0], w[0]);
    // Standard-mode purge invalidates and sends a single flush cycle.
    purgeIn <= 1'b1;
    wait_pulse(cacheInvalidate);
    purgeIn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check(nSpec, 3);
    check({28'h0, beSeen[3:0]}, {28'h0, WBB_BE_FLUSH2_B});
    check(nInval, 2);
    $display("test standard mode done");
    stopTest();
  end
endmodule
